// ==== rtl/core_sfr_pkg.sv ====
// constants for the core special-function register block
package core_sfr_pkg;
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 8;
    // special register offsets, identical in every bank except ADR_EEPROM_C, which maps to bank one
    localparam logic [7:0]  ADR_PORT0    = 8'h00;
    localparam logic [7:0]  ADR_PTR0     = 8'h01;
    localparam logic [7:0]  ADR_PORT1    = 8'h02;
    localparam logic [7:0]  ADR_PTR1     = 8'h03;
    localparam logic [7:0]  ADR_BANK     = 8'h04;
    localparam logic [7:0]  ADR_ACC      = 8'h05;
    localparam logic [7:0]  ADR_PCL      = 8'h06;
    localparam logic [7:0]  ADR_TBL_LO   = 8'h07;
    localparam logic [7:0]  ADR_TBL_LAT  = 8'h08;
    localparam logic [7:0]  ADR_TBL_HI   = 8'h09;
    localparam logic [7:0]  ADR_STATUS   = 8'h0a;
    localparam logic [7:0]  ADR_EEPROM_C = 8'h40;
    localparam logic [7:0]  ADR_SFR_TOP  = 8'h80;
    localparam logic [7:0]  EEPROM_BANK  = 8'h01;
    // status bit positions
    localparam int          ST_C         = 0;
    localparam int          ST_AC        = 1;
    localparam int          ST_Z         = 2;
    localparam int          ST_OV        = 3;
    localparam int          ST_PDF       = 4;
    localparam int          ST_TO        = 5;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  ARITH_MASK   = 4'hf;
    typedef enum logic [3:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
        OP_RRC, OP_RLC, OP_LDA
    } alu_op_t;
endpackage : core_sfr_pkg

// ==== rtl/core_special_registers.sv ====
// core special-function registers: pointers, bank, acc, pcl, table, status
// Functional notes
// [RULE_01] indirect ports redirect to their pointer address
// [RULE_02] port zero bank 0; port one uses bank
// [RULE_03] indirect port as target: read 00, no write
// [RULE_04] memory pointers are real read-write registers
// [RULE_05] direct operands always reach bank 0
// [RULE_06] reset clears bank, except watchdog in halt
// [RULE_07] special area shared, eeprom control bank one
// [RULE_08] two-bit bank field, upper bits read zero
// [RULE_09] three-bit bank field, codes 11x undefined
// [RULE_10] alu results land in the accumulator
// [RULE_11] pcl write jumps in page, one dummy cycle
// [RULE_12] table read: high to latch, low out
// [RULE_13] status writes keep watchdog and halt flags
// [RULE_14] carry on add carry or no borrow
// [RULE_15] half carry from the low nibble
// [RULE_16] zero flag on zero result
// [RULE_17] overflow when carries into/out of top differ
// [RULE_18] halt flag: set halt, clear power-up/clear
// [RULE_19] watchdog flag: set timeout, clear otherwise
// [RULE_20] status never saved automatically on call
// [RULE_21] undefined bank code reads 00, ignores writes
`timescale 1ns/1ns
module core_special_registers #(
    parameter int BANK_W    = 2,
    parameter int NUM_BANKS = 4,
    parameter int PC_W      = 12
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               rst_is_por,
    input  wire logic               rst_is_wdt_halt,
    // operand access from the execution unit
    input  wire logic [7:0]         op_addr,
    input  wire logic               op_rd,
    input  wire logic               op_wr,
    input  wire logic [7:0]         op_wdata,
    output logic [7:0]              op_rdata,
    output logic                    op_rvalid,
    // data memory and other special registers
    output logic [7:0]              mem_addr,
    output logic [BANK_W-1:0]       mem_bank,
    output logic                    mem_rd,
    output logic                    mem_we,
    output logic [7:0]              mem_wdata,
    input  wire logic [7:0]         mem_rdata,
    // alu
    input  wire logic               alu_go,
    input  wire core_sfr_pkg::alu_op_t alu_op,
    input  wire logic [7:0]         alu_b,
    output logic [7:0]              acc_value,
    // program counter
    input  wire logic [PC_W-1:0]    pc_cur,
    output logic                    pc_load,
    output logic [PC_W-1:0]         pc_load_addr,
    output logic                    pc_dummy,
    // table read
    input  wire logic               tbl_rd,
    output logic [15:0]             rom_addr,
    input  wire logic [15:0]        rom_data,
    output logic [7:0]              tbl_low,
    output logic                    tbl_low_valid,
    // system events
    input  wire logic               halt_exec,
    input  wire logic               clrwdt_exec,
    input  wire logic               wdt_timeout,
    output logic [7:0]              status_value
);
    logic [7:0]        ptr0_q, ptr1_q, acc_q, tbl_lo_q, tbl_hi_q, tbl_lat_q;
    logic [BANK_W-1:0] bank_q;
    logic [3:0]        flags_q;
    logic [7:0]        eff_addr, loc_rdata, rd_d, res;
    logic              indirect1, is_port, bank_ok, is_local, rd_en, wr_en;
    logic [8:0]        sum9;
    logic [4:0]        sum5;
    logic [7:0]        sum8, bx;
    logic              cin, c_n, ac_n, ov_n, to_q, pdf_q;

    // effective address and bank
    always_comb begin
        indirect1 = (op_addr == core_sfr_pkg::ADR_PORT1);
        if (op_addr == core_sfr_pkg::ADR_PORT0)
            eff_addr = ptr0_q;                                  // [RULE_01]
        else if (indirect1)
            eff_addr = ptr1_q;                                  // [RULE_01]
        else
            eff_addr = op_addr;
        is_port = (eff_addr == core_sfr_pkg::ADR_PORT0) ||
                  (eff_addr == core_sfr_pkg::ADR_PORT1);        // [RULE_03]
        // unused codes would alias a missing bank, so block them
        bank_ok = !indirect1 ||
                  (32'(bank_q) < 32'(NUM_BANKS));               // [RULE_21]
        is_local = (eff_addr <= core_sfr_pkg::ADR_STATUS);
        rd_en = op_rd && !is_port && bank_ok;                   // [RULE_03]
        wr_en = op_wr && !is_port && bank_ok;                   // [RULE_21]
    end

    // bank only follows the pointer through port one
    always_comb begin
        mem_bank = '0;                                          // [RULE_05]
        if (indirect1 && eff_addr >= core_sfr_pkg::ADR_SFR_TOP)
            mem_bank = bank_q;                                  // [RULE_02]
        else if (indirect1 && eff_addr == core_sfr_pkg::ADR_EEPROM_C &&
                 32'(bank_q) == 32'(core_sfr_pkg::EEPROM_BANK))
            mem_bank = bank_q;                                  // [RULE_07]
        mem_addr  = eff_addr;
        mem_rd    = rd_en && !is_local;
        mem_we    = wr_en && !is_local;
        mem_wdata = op_wdata;
    end

    always_comb begin
        case (eff_addr)
            core_sfr_pkg::ADR_PTR0:    loc_rdata = ptr0_q;      // [RULE_04]
            core_sfr_pkg::ADR_PTR1:    loc_rdata = ptr1_q;      // [RULE_04]
            core_sfr_pkg::ADR_BANK:    loc_rdata = 8'(bank_q);  // [RULE_08]
            core_sfr_pkg::ADR_ACC:     loc_rdata = acc_q;
            core_sfr_pkg::ADR_PCL:     loc_rdata = pc_cur[7:0];
            core_sfr_pkg::ADR_TBL_LO:  loc_rdata = tbl_lo_q;
            core_sfr_pkg::ADR_TBL_LAT: loc_rdata = tbl_lat_q;
            core_sfr_pkg::ADR_TBL_HI:  loc_rdata = tbl_hi_q;
            core_sfr_pkg::ADR_STATUS:  loc_rdata = status_value;
            default:                   loc_rdata = core_sfr_pkg::ZERO_BYTE;
        endcase
        if (!rd_en)
            rd_d = core_sfr_pkg::ZERO_BYTE;                     // [RULE_03]
        else if (is_local)
            rd_d = loc_rdata;
        else
            rd_d = mem_rdata;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_rdata  <= core_sfr_pkg::RST_BYTE;
            op_rvalid <= 1'b0;
        end else begin
            op_rdata  <= rd_d;
            op_rvalid <= op_rd;
        end
    end

    // pointers and table pointers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptr0_q   <= core_sfr_pkg::RST_BYTE;
            ptr1_q   <= core_sfr_pkg::RST_BYTE;
            tbl_lo_q <= core_sfr_pkg::RST_BYTE;
            tbl_hi_q <= core_sfr_pkg::RST_BYTE;
        end else if (wr_en) begin
            if (eff_addr == core_sfr_pkg::ADR_PTR0)
                ptr0_q <= op_wdata;                             // [RULE_04]
            if (eff_addr == core_sfr_pkg::ADR_PTR1)
                ptr1_q <= op_wdata;                             // [RULE_04]
            if (eff_addr == core_sfr_pkg::ADR_TBL_LO)
                tbl_lo_q <= op_wdata;
            if (eff_addr == core_sfr_pkg::ADR_TBL_HI)
                tbl_hi_q <= op_wdata;
        end
    end

    // bank survives a watchdog wake from halt
    always_ff @(posedge core_clk) begin
        if (rst) begin
            if (!rst_is_wdt_halt)
                bank_q <= '0;                                   // [RULE_06]
        end else if (wr_en && eff_addr == core_sfr_pkg::ADR_BANK) begin
            bank_q <= op_wdata[BANK_W-1:0];                     // [RULE_09]
        end
    end

    // alu datapath; results go to the accumulator, which a direct write can also load
    always_comb begin
        bx  = alu_b;
        cin = 1'b0;
        case (alu_op)
            core_sfr_pkg::OP_ADC: cin = flags_q[core_sfr_pkg::ST_C];
            core_sfr_pkg::OP_SUB: begin
                bx  = ~alu_b;
                cin = 1'b1;
            end
            core_sfr_pkg::OP_SBC: begin
                bx  = ~alu_b;
                cin = flags_q[core_sfr_pkg::ST_C];
            end
            default: ;
        endcase
        sum9 = {1'b0, acc_q} + {1'b0, bx} + {8'h00, cin};
        sum5 = {1'b0, acc_q[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        sum8 = {1'b0, acc_q[6:0]} + {1'b0, bx[6:0]} + {7'h00, cin};
        c_n  = sum9[8];                                         // [RULE_14]
        ac_n = sum5[4];                                         // [RULE_15]
        ov_n = sum8[7] ^ sum9[8];                               // [RULE_17]
        case (alu_op)
            core_sfr_pkg::OP_AND: res = acc_q & alu_b;
            core_sfr_pkg::OP_OR:  res = acc_q | alu_b;
            core_sfr_pkg::OP_XOR: res = acc_q ^ alu_b;
            core_sfr_pkg::OP_RRC: begin
                res  = {flags_q[core_sfr_pkg::ST_C], acc_q[7:1]};
                c_n  = acc_q[0];                                // [RULE_14]
            end
            core_sfr_pkg::OP_RLC: begin
                res  = {acc_q[6:0], flags_q[core_sfr_pkg::ST_C]};
                c_n  = acc_q[7];                                // [RULE_14]
            end
            core_sfr_pkg::OP_LDA: res = alu_b;
            default:              res = sum9[7:0];
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            acc_q <= core_sfr_pkg::RST_BYTE;
        else if (alu_go)
            acc_q <= res;                                       // [RULE_10]
        else if (wr_en && eff_addr == core_sfr_pkg::ADR_ACC)
            acc_q <= op_wdata;
    end

    // arithmetic flags; alu update wins over a software write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_q <= '0;
        end else if (alu_go) begin
            case (alu_op)
                core_sfr_pkg::OP_AND, core_sfr_pkg::OP_OR,
                core_sfr_pkg::OP_XOR:
                    flags_q[core_sfr_pkg::ST_Z] <= (res == 8'h00); // [RULE_16]
                core_sfr_pkg::OP_RRC, core_sfr_pkg::OP_RLC:
                    flags_q[core_sfr_pkg::ST_C] <= c_n;         // [RULE_14]
                core_sfr_pkg::OP_LDA: ;
                default: begin
                    flags_q[core_sfr_pkg::ST_C]  <= c_n;        // [RULE_14]
                    flags_q[core_sfr_pkg::ST_AC] <= ac_n;       // [RULE_15]
                    flags_q[core_sfr_pkg::ST_Z] <= (res == 8'h00); // [RULE_16]
                    flags_q[core_sfr_pkg::ST_OV] <= ov_n;       // [RULE_17]
                end
            endcase
        end else if (wr_en && eff_addr == core_sfr_pkg::ADR_STATUS) begin
            flags_q <= op_wdata[3:0] & core_sfr_pkg::ARITH_MASK; // [RULE_13]
        end
    end

    // system flags: only por, clear, halt and timeout touch them
    always_ff @(posedge core_clk) begin
        if (rst && rst_is_por) begin
            pdf_q <= 1'b0;                                      // [RULE_18]
            to_q  <= 1'b0;                                      // [RULE_19]
        end else begin
            if (halt_exec)
                pdf_q <= 1'b1;                                  // [RULE_18]
            else if (clrwdt_exec)
                pdf_q <= 1'b0;                                  // [RULE_18]
            if (wdt_timeout)
                to_q <= 1'b1;                                   // [RULE_19]
            else if (clrwdt_exec || halt_exec)
                to_q <= 1'b0;                                   // [RULE_19]
        end
    end
    // no save path exists for calls or interrupts
    assign status_value = {2'b00, to_q, pdf_q, flags_q};       // [RULE_20]
    assign acc_value    = acc_q;

    // pcl write: in-page jump plus one dummy cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_load      <= 1'b0;
            pc_load_addr <= '0;
            pc_dummy     <= 1'b0;
        end else begin
            pc_load  <= wr_en && (eff_addr == core_sfr_pkg::ADR_PCL);
            pc_dummy <= pc_load;                                // [RULE_11]
            if (wr_en && eff_addr == core_sfr_pkg::ADR_PCL)
                pc_load_addr <= {pc_cur[PC_W-1:8], op_wdata};   // [RULE_11]
        end
    end

    // table read: rom answers combinationally to rom_addr
    assign rom_addr = {tbl_hi_q, tbl_lo_q};                     // [RULE_12]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tbl_lat_q     <= core_sfr_pkg::RST_BYTE;
            tbl_low       <= core_sfr_pkg::RST_BYTE;
            tbl_low_valid <= 1'b0;
        end else begin
            tbl_low_valid <= tbl_rd;
            if (tbl_rd) begin
                tbl_lat_q <= rom_data[15:8];                    // [RULE_12]
                tbl_low   <= rom_data[7:0];                     // [RULE_12]
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_port_reads_zero: assert property ( // [RULE_03]
        op_rd && is_port |=> op_rvalid && op_rdata == 8'h00)
        else $error("indirect port self read not zero");
    chk_port_no_write: assert property ( // [RULE_03]
        op_wr && is_port |-> !mem_we)
        else $error("indirect port self write reached memory");
    chk_direct_bank0: assert property ( // [RULE_05]
        !indirect1 |-> mem_bank == '0)
        else $error("direct access left bank zero");
    chk_ptr_redirect: assert property ( // [RULE_01]
        op_addr == core_sfr_pkg::ADR_PORT1 |-> mem_addr == ptr1_q)
        else $error("port one not redirected");
    chk_undef_bank: assert property ( // [RULE_21]
        op_wr && indirect1 && 32'(bank_q) >= 32'(NUM_BANKS) |-> !mem_we)
        else $error("write through undefined bank");
    chk_pcl_dummy: assert property ( // [RULE_11]
        op_wr && !is_port && bank_ok &&
        eff_addr == core_sfr_pkg::ADR_PCL |=> pc_load ##1 pc_dummy)
        else $error("pcl write lacks jump or dummy");
    chk_status_sysflags: assert property ( // [RULE_13]
        wr_en && eff_addr == core_sfr_pkg::ADR_STATUS &&
        !halt_exec && !clrwdt_exec && !wdt_timeout |=> $stable(to_q) &&
        $stable(pdf_q))
        else $error("status write changed system flags");
    chk_halt_sets: assert property ( // [RULE_18]
        halt_exec && !wdt_timeout |=> pdf_q && !to_q)
        else $error("halt flags wrong");
    chk_timeout_sets: assert property ( // [RULE_19]
        wdt_timeout |=> to_q)
        else $error("timeout flag not set");
    chk_zero_flag: assert property ( // [RULE_16]
        alu_go && alu_op == core_sfr_pkg::OP_ADD |=>
        flags_q[core_sfr_pkg::ST_Z] == (acc_q == 8'h00))
        else $error("zero flag mismatch");
    chk_table_latch: assert property ( // [RULE_12]
        tbl_rd |=> tbl_lat_q == $past(rom_data[15:8]) && tbl_low_valid)
        else $error("table latch wrong");
    cov_indirect_far: cover property (mem_we && mem_bank != '0);
    cov_pcl_jump: cover property (pc_load ##1 pc_dummy);
    cov_carry_add: cover property (alu_go && c_n);
endmodule : core_special_registers

// ==== tb/exec_side_memory.sv ====
// data and program memory model standing behind the register block
`timescale 1ns/1ns
module exec_side_memory #(
    parameter int BANK_W = 2
) (
    // clock
    input  wire logic              core_clk,
    // data memory
    input  wire logic [7:0]        mem_addr,
    input  wire logic [BANK_W-1:0] mem_bank,
    input  wire logic              mem_rd,
    input  wire logic              mem_we,
    input  wire logic [7:0]        mem_wdata,
    output logic [7:0]             mem_rdata,
    // program memory
    input  wire logic [15:0]       rom_addr,
    output logic [15:0]            rom_data
);
    logic [7:0] mem [8][256];
    logic [7:0] last_q;

    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_bank][mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            last_q <= mem_rdata;
        end
    end

    // idle bus shows the inverse, so a stale sample never passes
    always_comb begin
        mem_rdata = mem_rd ? mem[mem_bank][mem_addr] : ~last_q;
    end

    assign rom_data = rom_addr ^ 16'h5aa5;
endmodule : exec_side_memory

// ==== tb/testbench.sv ====
// self-checking bench for the core special-function registers
`timescale 1ns/1ns
module testbench;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  rst_is_por = 1'b1;
    logic                  rst_is_wdt_halt = 1'b0;
    logic [7:0]            op_addr = 8'h00;
    logic [7:0]            op_wdata = 8'h00;
    logic                  op_rd = 1'b0;
    logic                  op_wr = 1'b0;
    logic                  alu_go = 1'b0;
    logic [7:0]            alu_b = 8'h00;
    core_sfr_pkg::alu_op_t alu_op = core_sfr_pkg::OP_LDA;
    logic [11:0]           pc_cur = 12'h5a3;
    logic                  tbl_rd = 1'b0;
    logic                  halt_exec = 1'b0;
    logic                  clrwdt_exec = 1'b0;
    logic                  wdt_timeout = 1'b0;
    logic [7:0]            op_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [7:0]            acc_value, tbl_low, status_value, rdv;
    logic                  op_rvalid, mem_rd, mem_we, pc_load, pc_dummy;
    logic                  tbl_low_valid;
    logic [1:0]            mem_bank;
    logic [11:0]           pc_load_addr;
    logic [15:0]           rom_addr, rom_data;
    int                    err_count = 0;
    int                    comparisons = 0;

    core_special_registers #(.BANK_W(2), .NUM_BANKS(3), .PC_W(12)) i_dut (
        .core_clk, .rst, .rst_is_por, .rst_is_wdt_halt,
        .op_addr, .op_rd, .op_wr, .op_wdata, .op_rdata, .op_rvalid,
        .mem_addr, .mem_bank, .mem_rd, .mem_we, .mem_wdata, .mem_rdata,
        .alu_go, .alu_op, .alu_b, .acc_value,
        .pc_cur, .pc_load, .pc_load_addr, .pc_dummy,
        .tbl_rd, .rom_addr, .rom_data, .tbl_low, .tbl_low_valid,
        .halt_exec, .clrwdt_exec, .wdt_timeout, .status_value
    );

    exec_side_memory #(.BANK_W(2)) i_mem (
        .core_clk, .mem_addr, .mem_bank, .mem_rd, .mem_we, .mem_wdata,
        .mem_rdata, .rom_addr, .rom_data
    );

    always #5 core_clk = ~core_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("mismatches %0d of %0d checks", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        op_wr = 1'b1;
        op_addr = a;
        op_wdata = d;
        @(negedge core_clk);
        op_wr = 1'b0;
    endtask : wr

    // read data stands one cycle only, so it is taken right here
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        op_rd = 1'b1;
        op_addr = a;
        @(negedge core_clk);
        op_rd = 1'b0;
        check(op_rvalid, 1'b1);
        rdv = op_rdata;
    endtask : rd

    // 0 table read, 1 halt, 2 watchdog clear, 3 watchdog timeout
    task automatic pulse(input int sel);
        @(negedge core_clk);
        case (sel)
            0: tbl_rd = 1'b1;
            1: halt_exec = 1'b1;
            2: clrwdt_exec = 1'b1;
            default: wdt_timeout = 1'b1;
        endcase
        @(negedge core_clk);
        tbl_rd = 1'b0;
        halt_exec = 1'b0;
        clrwdt_exec = 1'b0;
        wdt_timeout = 1'b0;
    endtask : pulse

    task automatic do_rst(input logic por, input logic wh);
        @(negedge core_clk);
        rst = 1'b1;
        rst_is_por = por;
        rst_is_wdt_halt = wh;
        @(negedge core_clk);
        rst = 1'b0;
        rst_is_por = 1'b0;
        rst_is_wdt_halt = 1'b0;
    endtask : do_rst

    task automatic t_reset();
        rd(core_sfr_pkg::ADR_BANK);
        check(rdv, 8'h00);
        check(status_value, 8'h00);
    endtask : t_reset

    task automatic t_indirect();
        wr(core_sfr_pkg::ADR_BANK, 8'h01);
        wr(core_sfr_pkg::ADR_PTR0, 8'h90);
        wr(core_sfr_pkg::ADR_PORT0, 8'h11);
        check(i_mem.mem[0][8'h90], 8'h11);
        wr(core_sfr_pkg::ADR_PTR1, 8'h90);
        wr(core_sfr_pkg::ADR_PORT1, 8'h22);
        check(i_mem.mem[1][8'h90], 8'h22);
        wr(8'h91, 8'h33);
        check(i_mem.mem[0][8'h91], 8'h33);
        rd(core_sfr_pkg::ADR_PORT1);
        check(rdv, 8'h22);
        rd(core_sfr_pkg::ADR_PTR1);
        check(rdv, 8'h90);
        wr(core_sfr_pkg::ADR_PTR0, core_sfr_pkg::ADR_PORT1);
        wr(core_sfr_pkg::ADR_PORT0, 8'h55);
        rd(core_sfr_pkg::ADR_PORT0);
        check(rdv, 8'h00);
        wr(core_sfr_pkg::ADR_PTR1, core_sfr_pkg::ADR_EEPROM_C);
        wr(core_sfr_pkg::ADR_PORT1, 8'h77);
        wr(core_sfr_pkg::ADR_EEPROM_C, 8'h66);
        check(i_mem.mem[1][8'h40], 8'h77);
        check(i_mem.mem[0][8'h40], 8'h66);
        wr(core_sfr_pkg::ADR_BANK, 8'h02);
        wr(core_sfr_pkg::ADR_PTR1, core_sfr_pkg::ADR_PTR0);
        rd(core_sfr_pkg::ADR_PORT1);
        check(rdv, {6'h00, 2'h2});
        wr(core_sfr_pkg::ADR_BANK, 8'hff);
        rd(core_sfr_pkg::ADR_BANK);
        check(rdv, 8'h03);
        wr(core_sfr_pkg::ADR_PTR1, 8'h90);
        rd(core_sfr_pkg::ADR_PORT1);
        check(rdv, 8'h00);
        wr(core_sfr_pkg::ADR_PORT1, 8'h5a);
        check(i_mem.mem[3][8'h90], 8'hxx);
        wr(core_sfr_pkg::ADR_BANK, 8'h01);
        rd(core_sfr_pkg::ADR_PORT1);
        check(rdv, 8'h22);
        wr(core_sfr_pkg::ADR_BANK, 8'h00);
    endtask : t_indirect

    // each entry: op, operand, expected acc, expected {ov,z,ac,c}
    task automatic t_alu();
        logic [23:0] v [13] = '{24'h97f7f0, 24'h00180a, 24'h08000d,
            24'h100010, 24'h201007, 24'h301ff0, 24'h800fe1, 24'h700ff0,
            24'h400004, 24'h580800, 24'h680004, 24'h980804, 24'h2017f9};
        for (int i = 0; i < 13; i++) begin
            @(negedge core_clk);
            alu_go = 1'b1;
            alu_op = core_sfr_pkg::alu_op_t'(v[i][23:20]);
            alu_b = v[i][19:12];
            @(negedge core_clk);
            alu_go = 1'b0;
            check(acc_value, v[i][11:4]);
            check(status_value[1:0], v[i][1:0]);
            check(status_value[7:2], {4'h0, v[i][3:2]});
        end
    endtask : t_alu

    task automatic t_pcl_table();
        wr(core_sfr_pkg::ADR_PCL, 8'h42);
        check(pc_load, 1'b1);
        check(pc_load_addr, 12'h542);
        @(negedge core_clk);
        check({pc_load, pc_dummy}, 2'b01);
        wr(core_sfr_pkg::ADR_TBL_LO, 8'h34);
        wr(core_sfr_pkg::ADR_TBL_HI, 8'h12);
        check(rom_addr, 16'h1234);
        pulse(0);
        check({tbl_low_valid, tbl_low}, 9'h191);
        rd(core_sfr_pkg::ADR_TBL_LAT);
        check(rdv, 8'h48);
        wr(core_sfr_pkg::ADR_ACC, 8'h3c);
        check(acc_value, 8'h3c);
        rd(core_sfr_pkg::ADR_PCL);
        check(rdv, 8'ha3);
    endtask : t_pcl_table

    task automatic t_status();
        pulse(1);
        pulse(3);
        check(status_value, 8'h39);
        wr(core_sfr_pkg::ADR_STATUS, 8'h00);
        check(status_value, 8'h30);
        wr(core_sfr_pkg::ADR_STATUS, 8'h0f);
        check(status_value, 8'h3f);
        rd(core_sfr_pkg::ADR_STATUS);
        check(rdv, 8'h3f);
        wr(core_sfr_pkg::ADR_BANK, 8'h02);
        do_rst(1'b0, 1'b1);
        rd(core_sfr_pkg::ADR_BANK);
        check(rdv, 8'h02);
        check(status_value, 8'h30);
        pulse(1);
        check(status_value, 8'h10);
        pulse(2);
        check(status_value, 8'h00);
        do_rst(1'b0, 1'b0);
        rd(core_sfr_pkg::ADR_BANK);
        check(rdv, 8'h00);
        pulse(1);
        do_rst(1'b1, 1'b0);
        check(status_value, 8'h00);
    endtask : t_status

    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        rst_is_por = 1'b0;
        t_reset();
        t_indirect();
        t_alu();
        t_pcl_table();
        t_status();
        final_report();
    end

    // cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        final_report();
    end
endmodule : testbench
